// [rtl/octal_uart_map_decoder.v]
// memory window decoder for an eight-channel uart: control, config, rx, tx and rx-with-status regions
`timescale 1ns/1ps
`include "uart_map_regs.vh"
module octal_uart_map_decoder (
   // clock and reset
   input  wire        clock,
   input  wire        sys_rst,
   // window base programmed by the host (address bits 31:12)
   input  wire [19:0] memBase,
   // host memory request
   input  wire        reqValid,
   output wire        reqReady,
   input  wire        reqWrite,
   input  wire [31:0] reqAddr,
   input  wire [3:0]  reqByteEn,
   input  wire [31:0] reqWdata,
   // host answer
   output wire        rspValid,
   output reg  [31:0] rspRdata,
   output reg         rspMiss,
   // downstream read port toward the channels
   output reg         rdReq,
   output reg  [1:0]  rdKind,
   output reg  [2:0]  rdChan,
   output reg  [8:0]  rdOffset,
   output reg  [3:0]  rdByteEn,
   output reg  [2:0]  rdCount,
   input  wire        rdAck,
   input  wire [31:0] rdData,
   // downstream register write port
   output reg         wrStb,
   output reg         wrCfg,
   output reg  [2:0]  wrChan,
   output reg  [8:0]  wrOffset,
   output reg  [3:0]  wrByteEn,
   output reg  [31:0] wrData,
   // transmit data stream toward the channels
   output wire        txValid,
   input  wire        txReady,
   output wire [2:0]  txChan,
   output wire [2:0]  txCount,
   output wire [31:0] txData
);

   // ----------------------------------------
   // state encoding
   // ----------------------------------------
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_WAIT = 3'b010;
   localparam [2:0] ST_RESP = 3'b100;

   reg  [2:0] state_r;
   reg  [2:0] state_nxt;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function [2:0] countBytes;
      input [3:0] be;
      begin
         countBytes = {2'b00, be[0]} + {2'b00, be[1]} + {2'b00, be[2]} + {2'b00, be[3]};
      end
   endfunction

   function inRange;
      input [8:0] off;
      input [8:0] lo;
      input [8:0] hi;
      begin
         inRange = (off >= lo) && (off <= hi);
      end
   endfunction

   // ----------------------------------------
   // decode of the incoming request
   // ----------------------------------------
   wire [2:0] chan;
   wire [8:0] offset;
   wire [2:0] nBytes;
   wire       hit;
   wire       isCtrl;
   wire       isCfg;
   wire       isFifo;
   wire       isRxErr;
   wire       rxErrWidthOk;
   wire       txWrite;
   wire       fifoInReady;
   wire       taken;

   assign chan    = reqAddr[`CHAN_MSB:`CHAN_LSB];
   // offset of the first enabled byte lane
   assign offset  = {reqAddr[8:2], reqByteEn[0] ? 2'd0 : reqByteEn[1] ? 2'd1 : reqByteEn[2] ? 2'd2 : 2'd3};
   assign nBytes  = countBytes(reqByteEn);
   assign hit     = (reqAddr[31:`WINDOW_BITS] == memBase);
   assign isCtrl  = inRange(offset, `CTRL_FIRST, `CTRL_LAST);
   assign isCfg   = (chan == 3'd0) && inRange(offset, `CFG_FIRST, `CFG_LAST);
   assign isFifo  = inRange(offset, `FIFO_FIRST, `FIFO_LAST);
   assign isRxErr = inRange(offset, `RXERR_FIRST, `RXERR_LAST);
   // only whole data/status pairs may be unloaded
   assign rxErrWidthOk = (reqByteEn == 4'h3) || (reqByteEn == 4'hC) || (reqByteEn == 4'hF);
   assign txWrite = hit && reqWrite && isFifo && (reqByteEn != 4'h0);

   // back-pressure from the transmit queue stalls the host request
   assign reqReady = (state_r == ST_IDLE) && (!txWrite || fifoInReady);
   assign taken    = reqValid && reqReady;
   assign rspValid = (state_r == ST_RESP);

   // ----------------------------------------
   // state machine
   // ----------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (taken) begin
               if (hit && !reqWrite && (reqByteEn != 4'h0) &&
                   (isCtrl || isCfg || isFifo || (isRxErr && rxErrWidthOk))) begin
                  state_nxt = ST_WAIT;
               end else begin
                  state_nxt = ST_RESP;
               end
            end
         end
         ST_WAIT: begin
            if (rdAck) begin
               state_nxt = ST_RESP;
            end
         end
         ST_RESP: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge clock) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------
   // downstream read issue and answer capture
   // ----------------------------------------
   always @(posedge clock) begin
      if (sys_rst) begin
         rdReq    <= 1'b0;
         rdKind   <= `KIND_CTRL;
         rdChan   <= 3'd0;
         rdOffset <= 9'h000;
         rdByteEn <= 4'h0;
         rdCount  <= 3'd0;
         rspRdata <= `RDATA_RESET;
         rspMiss  <= 1'b0;
      end else begin
         rdReq <= 1'b0;
         if (taken) begin
            rspRdata <= `RDATA_RESET;
            rspMiss  <= !hit;
            rdChan   <= chan;
            rdOffset <= offset;
            rdByteEn <= reqByteEn;
            rdCount  <= 3'd0;
            if (hit && !reqWrite && (reqByteEn != 4'h0)) begin
               if (isCtrl) begin
                  rdReq  <= 1'b1;
                  rdKind <= `KIND_CTRL;
               end else if (isCfg) begin
                  rdReq  <= 1'b1;
                  rdKind <= `KIND_CFG;
               end else if (isFifo) begin
                  rdReq   <= 1'b1;
                  rdKind  <= `KIND_RX;
                  rdCount <= nBytes;
               end else if (isRxErr && rxErrWidthOk) begin
                  rdReq   <= 1'b1;
                  rdKind  <= `KIND_RXERR;
                  rdCount <= {1'b0, nBytes[2:1]};
               end
            end
         end else if ((state_r == ST_WAIT) && rdAck) begin
            rspRdata <= rdData;
         end
      end
   end

   // ----------------------------------------
   // register writes to control and config areas
   // ----------------------------------------
   always @(posedge clock) begin
      if (sys_rst) begin
         wrStb    <= 1'b0;
         wrCfg    <= 1'b0;
         wrChan   <= 3'd0;
         wrOffset <= 9'h000;
         wrByteEn <= 4'h0;
         wrData   <= 32'h00000000;
      end else begin
         wrStb <= 1'b0;
         // writes to reserved offsets fall through and are dropped
         if (taken && hit && reqWrite && (reqByteEn != 4'h0) && (isCtrl || isCfg)) begin
            wrStb    <= 1'b1;
            wrCfg    <= isCfg;
            wrChan   <= chan;
            wrOffset <= offset;
            wrByteEn <= reqByteEn;
            wrData   <= reqWdata;
         end
      end
   end

   // ----------------------------------------
   // transmit write queue
   // ----------------------------------------
   wire [37:0] fifoOut;
   wire [31:0] packedData;

   // the word is shifted down so the first enabled byte sits in lane zero
   assign packedData = reqByteEn[0] ? reqWdata :
                       reqByteEn[1] ? {8'h00, reqWdata[31:8]} :
                       reqByteEn[2] ? {16'h0000, reqWdata[31:16]} :
                                      {24'h000000, reqWdata[31:24]};

   tx_word_fifo #(
      .WIDTH (38),
      .DEPTH (`TX_FIFO_DEPTH),
      .AW    (`TX_FIFO_AW)
   ) u_tx_fifo (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .inValid  (taken && txWrite),
      .inReady  (fifoInReady),
      .inData   ({chan, nBytes, packedData}),
      .outValid (txValid),
      .outReady (txReady),
      .outData  (fifoOut)
   );

   assign txChan  = fifoOut[37:35];
   assign txCount = fifoOut[34:32];
   assign txData  = fifoOut[31:0];

endmodule

// [rtl/uart_map_regs.vh]
// address map constants for the eight-channel uart memory window decoder
`ifndef UART_MAP_REGS_VH
`define UART_MAP_REGS_VH

// ----------------------------------------
// window and slice layout
// ----------------------------------------
`define WINDOW_BITS      12
`define SLICE_STRIDE     12'h200
`define CHAN_MSB         11
`define CHAN_LSB         9

// ----------------------------------------
// region bounds inside one slice (byte offsets)
// ----------------------------------------
`define CTRL_FIRST       9'h000
`define CTRL_LAST        9'h00F
`define CFG_FIRST        9'h080
`define CFG_LAST         9'h093
`define FIFO_FIRST       9'h100
`define FIFO_LAST        9'h13F
`define RXERR_FIRST      9'h180
`define RXERR_LAST       9'h1FF

// ----------------------------------------
// downstream access kinds
// ----------------------------------------
`define KIND_CTRL        2'h0
`define KIND_CFG         2'h1
`define KIND_RX          2'h2
`define KIND_RXERR       2'h3

// ----------------------------------------
// reset values and fifo shape
// ----------------------------------------
`define RDATA_RESET      32'h00000000
`define BASE_RESET       20'h00000
`define TX_FIFO_DEPTH    16
`define TX_FIFO_AW       4

`endif

// [rtl/tx_word_fifo.v]
// word fifo with registered head output, used to queue transmit fifo writes
`timescale 1ns/1ps
`include "uart_map_regs.vh"
module tx_word_fifo #(
   parameter WIDTH = 38,
   parameter DEPTH = `TX_FIFO_DEPTH,
   parameter AW    = `TX_FIFO_AW
) (
   // clock and reset
   input  wire             clock,
   input  wire             sys_rst,
   // filling side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // draining side
   output reg              outValid,
   input  wire             outReady,
   output reg  [WIDTH-1:0] outData
);

   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW:0]      wrPtr_r;
   reg  [AW:0]      rdPtr_r;
   wire [AW:0]      used;
   wire             memEmpty;
   wire             doPush;
   wire             doLoad;

   assign used     = wrPtr_r - rdPtr_r;
   assign memEmpty = (used == {(AW+1){1'b0}});
   assign inReady  = (used != DEPTH[AW:0]);
   assign doPush   = inValid && inReady;
   // refill the head register whenever it is free or being taken
   assign doLoad   = !memEmpty && (!outValid || outReady);

   always @(posedge clock) begin
      if (doPush) begin
         mem[wrPtr_r[AW-1:0]] <= inData;
      end
   end

   always @(posedge clock) begin
      if (sys_rst) begin
         wrPtr_r  <= {(AW+1){1'b0}};
         rdPtr_r  <= {(AW+1){1'b0}};
         outValid <= 1'b0;
         outData  <= {WIDTH{1'b0}};
      end else begin
         if (doPush) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (doLoad) begin
            outData  <= mem[rdPtr_r[AW-1:0]];
            outValid <= 1'b1;
            rdPtr_r  <= rdPtr_r + 1'b1;
         end else if (outReady) begin
            outValid <= 1'b0;
         end
      end
   end

endmodule

// [verif/map_decoder_assertions.sv]
// concurrent checks on the ports of the memory window decoder
`timescale 1ns/1ps
module map_decoder_checker (
   // clock and reset
   input wire        clock,
   input wire        sys_rst,
   // host side
   input wire [19:0] memBase,
   input wire        reqValid,
   input wire        reqReady,
   input wire        reqWrite,
   input wire [31:0] reqAddr,
   input wire [3:0]  reqByteEn,
   input wire        rspValid,
   input wire [31:0] rspRdata,
   input wire        rspMiss,
   // channel side
   input wire        rdReq,
   input wire [1:0]  rdKind,
   input wire [8:0]  rdOffset,
   input wire [2:0]  rdCount,
   input wire        wrStb,
   input wire        wrCfg,
   input wire        txValid,
   input wire        txReady,
   input wire [31:0] txData
);
   wire take = reqValid && reqReady;
   wire hit  = reqAddr[31:12] == memBase;
   wire rd   = take && hit && !reqWrite;
   wire wr   = take && hit && reqWrite;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   AST_MISS: assert property (take && !hit |=> rspValid && rspMiss && rspRdata == 32'h0)
      else $error("miss not answered");
   AST_CTRL: assert property (rd && reqAddr[8:4] == 5'h0 && reqByteEn == 4'hF
      |=> rdReq && rdKind == 2'h0 && rdOffset == $past({reqAddr[8:2], 2'b00})) else $error("ctrl read");
   AST_RX: assert property (rd && reqAddr[8:6] == 3'h4 && reqByteEn == 4'hF
      |=> rdReq && rdKind == 2'h2 && rdCount == 3'h4) else $error("rx read");
   AST_RXERR: assert property (rd && reqAddr[8:7] == 2'h3 && reqByteEn == 4'hF
      |=> rdReq && rdKind == 2'h3 && rdCount == 3'h2) else $error("rx status read");
   AST_RXBAD: assert property (rd && reqAddr[8:7] == 2'h3 && reqByteEn == 4'h1
      |=> rspValid && !rdReq && rspRdata == 32'h0) else $error("narrow status read");
   AST_CFG: assert property (wr && reqByteEn != 4'h0 && reqAddr[11:0] >= 12'h080 && reqAddr[11:0] <= 12'h090
      |=> wrStb && wrCfg) else $error("config write");
   AST_RESV: assert property (take && hit && reqAddr[8:6] == 3'h5
      |=> rspValid && !rdReq && !wrStb && rspRdata == 32'h0) else $error("reserved hole");
   AST_TXHOLD: assert property (txValid && !txReady |=> txValid && $stable(txData))
      else $error("tx head dropped");
endmodule
bind octal_uart_map_decoder map_decoder_checker chk_u (.*);

// [verif/chan_model.sv]
// channel-side model: answers downstream reads, takes transmit words
`timescale 1ns/1ps
module chan_model (
   // clock and reset
   input  wire        clock,
   input  wire        sys_rst,
   // downstream read port
   input  wire        rdReq,
   input  wire [1:0]  rdKind,
   input  wire [2:0]  rdChan,
   input  wire [8:0]  rdOffset,
   output reg         rdAck,
   output reg  [31:0] rdData,
   // transmit stream
   input  wire        stall,
   output wire        txReady
);
   reg [2:0]  wait_r;
   reg        slow_r;
   reg [31:0] pat_r;
   // -----------------------------------
   // answers alternate prompt and slow
   // -----------------------------------
   always @(posedge clock) begin
      if (sys_rst) begin
         wait_r <= 3'h0;
         slow_r <= 1'b0;
         rdAck  <= 1'b0;
         rdData <= 32'h0;
      end else begin
         rdAck  <= 1'b0;
         rdData <= ~rdData;
         if (rdReq) begin
            wait_r <= slow_r ? 3'h3 : 3'h1;
            slow_r <= ~slow_r;
            pat_r  <= {10'h2A5, rdKind, rdChan, rdOffset, 8'h00};
         end else if (wait_r != 3'h0)
            wait_r <= wait_r - 3'h1;
         if (wait_r == 3'h1) begin
            rdAck  <= 1'b1;
            rdData <= pat_r;
         end
      end
   end
   assign txReady = !stall;
endmodule

// [verif/octal_uart_memory_map_decoder_bench.sv]
// self-checking bench for the memory window decoder
`timescale 1ns/1ps
module octal_uart_memory_map_decoder_bench;
   localparam [19:0] BASE = 20'hABCDE;
   typedef struct packed {logic w; logic [11:0] a; logic [3:0] be; logic r; logic [1:0] k;
      logic [2:0] c; logic s; logic g;} row_t;
   row_t rows [16] = '{'{0,12'h004,4'hF,1,0,0,0,0}, '{0,12'h088,4'hF,1,1,0,0,0},
      '{0,12'h288,4'hF,0,0,0,0,0}, '{0,12'h100,4'hF,1,2,4,0,0}, '{0,12'h300,4'h2,1,2,1,0,0},
      '{0,12'h500,4'h7,1,2,3,0,0}, '{0,12'h780,4'hF,1,3,2,0,0}, '{0,12'h980,4'hC,1,3,1,0,0},
      '{0,12'hB80,4'h1,0,0,0,0,0}, '{0,12'hD40,4'hF,0,0,0,0,0}, '{0,12'hE10,4'hF,0,0,0,0,0},
      '{1,12'h208,4'hF,0,0,0,1,0}, '{1,12'h090,4'hF,0,0,0,1,1}, '{1,12'h290,4'hF,0,0,0,0,0},
      '{1,12'hF80,4'hF,0,0,0,0,0}, '{1,12'h000,4'h0,0,0,0,0,0}};
   logic        clock = 1'b0;
   logic        sysRst = 1'b1;
   logic        reqValid = 1'b0;
   logic        reqWrite = 1'b0;
   logic        stall = 1'b0;
   logic [31:0] reqAddr = 32'h0;
   logic [31:0] reqWdata = 32'h0;
   logic [3:0]  reqByteEn = 4'h0;
   wire         reqReady, rspValid, rspMiss, rdReq, rdAck, wrStb, wrCfg, txValid, txReady;
   wire  [31:0] rspRdata, rdData, txData, wrData;
   wire  [3:0]  rdByteEn, wrByteEn;
   wire  [1:0]  rdKind;
   wire  [2:0]  rdChan, rdCount, txChan, txCount, wrChan;
   wire  [8:0]  rdOffset, wrOffset;
   int          failures = 0;
   int          comparisons = 0;
   logic        sawRd, sawWr, cfgSeen, missSeen;
   logic [4:0]  rdSeen;
   logic [31:0] dataSeen;
   logic [31:0] wrDataSeen;
   logic [15:0] wrSeen;
   logic [3:0]  beSeen;
   logic [37:0] txLog [$];
   octal_uart_map_decoder dut_u (.clock, .sys_rst(sysRst), .memBase(BASE), .reqValid, .reqReady,
      .reqWrite, .reqAddr, .reqByteEn, .reqWdata, .rspValid, .rspRdata, .rspMiss, .rdReq, .rdKind,
      .rdChan, .rdOffset, .rdByteEn, .rdCount, .rdAck, .rdData, .wrStb, .wrCfg, .wrChan,
      .wrOffset, .wrByteEn, .wrData, .txValid, .txReady, .txChan, .txCount, .txData);
   chan_model mdl_u (.clock, .sys_rst(sysRst), .rdReq, .rdKind, .rdChan, .rdOffset, .rdAck,
      .rdData, .stall, .txReady);
   always #10 clock = ~clock;
   always @(posedge clock) if (txValid && txReady) txLog.push_back({txChan, txCount, txData});
   // ----------------------------------
   // helpers
   // ----------------------------------
   task chk(input string n, input logic [37:0] s, input logic [37:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s exp %h got %h", n, e, s);
      end
   endtask
   task finish_test;
      if (failures == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function logic [31:0] pat(input logic [11:0] a, input logic [3:0] b, input logic [1:0] k);
      pat = {10'h2A5, k, a[11:9], a[8:2], b[0] ? 2'h0 : b[1] ? 2'h1 : b[2] ? 2'h2 : 2'h3, 8'h00};
   endfunction
   task access(input logic w, input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
      int n;
      reqValid <= 1'b1;
      reqWrite <= w;
      reqAddr <= a;
      reqByteEn <= be;
      reqWdata <= d;
      sawRd = 0;
      sawWr = 0;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (!reqReady && n < 50);
      reqValid <= 1'b0;
      do begin
         @(posedge clock);
         n++;
         if (rdReq) {sawRd, rdSeen, beSeen} = {1'b1, rdKind, rdCount, rdByteEn};
         if (wrStb) {sawWr, cfgSeen, wrSeen, wrDataSeen} = {1'b1, wrCfg, wrChan, wrOffset, wrByteEn, wrData};
      end while (!rspValid && n < 80);
      {missSeen, dataSeen} = {rspMiss, rspRdata};
      if (n >= 80) begin
         failures++;
         finish_test;
      end
   endtask
   // ----------------------------------
   // main sequence
   // ----------------------------------
   initial begin
      repeat (20) @(posedge clock);
      sysRst <= 1'b0;
      foreach (rows[i]) begin
         access(rows[i].w, {BASE, rows[i].a}, rows[i].be, 32'h12345678);
         chk("rdReq", sawRd, rows[i].r);
         chk("rdata", dataSeen, rows[i].r ? pat(rows[i].a, rows[i].be, rows[i].k) : 32'h0);
         if (rows[i].r) chk("kind", rdSeen, {rows[i].k, rows[i].c});
         if (rows[i].r) chk("rdBe", beSeen, rows[i].be);
         chk("wrStb", {sawWr, sawWr & cfgSeen}, {rows[i].s, rows[i].g});
         if (rows[i].s) chk("wrPort", wrSeen, {rows[i].a, rows[i].be});
         if (rows[i].s) chk("wrData", wrDataSeen, 32'h12345678);
         chk("hitMiss", missSeen, 1'b0);
      end
      access(0, {~BASE, 12'h004}, 4'hF, 32'h0);
      chk("miss", {missSeen, sawRd, dataSeen}, {2'h2, 32'h0});
      stall <= 1'b1;
      for (int i = 0; i < 17; i++) access(1, {BASE, 12'h300}, 4'hF, 32'hA0 + i);
      // queue is full now: this request must stay refused while the consumer stalls
      reqValid <= 1'b1;
      reqWrite <= 1'b1;
      reqAddr <= {BASE, 12'h300};
      reqByteEn <= 4'h6;
      reqWdata <= 32'h00BBCC00;
      repeat (3) @(posedge clock);
      chk("ready", {reqReady, rspValid}, 2'h0);
      stall <= 1'b0;
      access(1, {BASE, 12'h300}, 4'h6, 32'h00BBCC00);
      for (int n = 0; n < 100 && txLog.size() < 18; n++) @(posedge clock);
      chk("txCount", txLog.size(), 18);
      if (txLog.size() < 18) finish_test;
      for (int i = 0; i < 17; i++) chk("tx", txLog.pop_front(), {6'hC, 32'hA0 + i});
      chk("txPack", txLog.pop_front() & 38'h3F0000FFFF, {6'hA, 32'hBBCC});
      stall <= 1'b1;
      access(1, {BASE, 12'h100}, 4'hF, 32'h55);
      sysRst <= 1'b1;
      repeat (2) @(posedge clock);
      chk("reset", {txValid, reqReady, rspValid}, 3'h2);
      sysRst <= 1'b0;
      stall <= 1'b0;
      access(0, {BASE, 12'h004}, 4'hF, 32'h0);
      chk("after", dataSeen, pat(12'h004, 4'hF, 2'h0));
      chk("txDrop", txLog.size(), 0);
      finish_test;
   end
endmodule
